// File: src/ssl_top.sv
// Front-panel sync LEDs, reset button timing, boot and service supervision
`include "ssl_regs.svh"
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Locked and regulated: red off, green steady.
// - Locked with hold-off timer running: red off, green flashing.
// - Locked in simulation mode: red flashing, green steady.
// - Quartz with acquire timer running: both flashing.
// - Quartz, time set from source: both steady.
// - Quartz, time set manually: red steady, green flashing; after reset red steady, green off.
// - Module fault: red fast flash, green off, time not valid.
// - Settings missing: red and green fast flash in opposite phase, time not valid.
// - No supply: both LEDs off.
// - Press under one second ignored; one to nine seconds gives hardware reset.
// - Ten to nineteen seconds: user preset restore, reboot ten seconds later.
// - Twenty seconds or more: shipping preset restore, reboot ten seconds later.
// - User restore without saved user preset becomes shipping restore.
// - Network unreachable while booting; ready and service LED after boot time.
// - Antenna short or open input raises an error indication.
// - Top stratum reported only after settle time in locked and regulated state.
// - Host polls source data and forwards settings without delay.
module ssl_top
#(
   parameter int unsigned SEC_CYC      = `SSL_SEC_CYC,
   parameter int unsigned DEBOUNCE_CYC = `SSL_DEBOUNCE_CYC,
   parameter int unsigned BOOT_S       = `SSL_BOOT_S,
   parameter int unsigned SETTLE_S     = `SSL_SETTLE_S,
   parameter int unsigned REBOOT_S     = `SSL_REBOOT_S
)
(
   input  wire logic                      aclk,
   input  wire logic                      aresetn,
   input  wire logic [`SSL_ADDR_W-1:0]    s_axi_awaddr,
   input  wire logic                      s_axi_awvalid,
   output var  logic                      s_axi_awready,
   input  wire logic [31:0]               s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   input  wire logic                      s_axi_wvalid,
   output var  logic                      s_axi_wready,
   output var  logic [1:0]                s_axi_bresp,
   output var  logic                      s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   input  wire logic [`SSL_ADDR_W-1:0]    s_axi_araddr,
   input  wire logic                      s_axi_arvalid,
   output var  logic                      s_axi_arready,
   output var  logic [31:0]               s_axi_rdata,
   output var  logic [1:0]                s_axi_rresp,
   output var  logic                      s_axi_rvalid,
   input  wire logic                      s_axi_rready,
   input  wire logic                      button_n,
   input  wire logic                      supply_ok,
   input  wire logic                      general_module_fault,
   input  wire logic                      antenna_short,
   input  wire logic                      antenna_open,
   output var  logic                      red_indicator,
   output var  logic                      green_indicator,
   output var  logic                      service_indicator,
   output var  logic                      time_not_valid,
   output var  logic                      antenna_fault,
   output var  logic                      net_ready,
   output var  logic                      stratum_top,
   output var  logic                      hw_reset_req,
   output var  logic                      user_preset_restore,
   output var  logic                      shipping_preset_restore,
   output var  logic                      reboot_req,
   output var  logic                      irq
);
   import ssl_pkg::*;

   if (SEC_CYC < 6 || DEBOUNCE_CYC < 1 || BOOT_S < 1 || SETTLE_S < 1 || REBOOT_S < 1)
   begin : g_bad
      $error("ssl_top: timing parameters too small");
   end

   localparam int unsigned SW = $clog2(SEC_CYC);
   localparam int unsigned DW = (DEBOUNCE_CYC > 1) ? $clog2(DEBOUNCE_CYC + 1) : 1;
   localparam int unsigned LW = 16;

   // Pin synchronisers
   logic [4:0] pin_s1;
   logic [4:0] pin_s2;
   always_ff @(posedge aclk)
   begin
      pin_s1 <= {~button_n, supply_ok, general_module_fault, antenna_short, antenna_open};
      pin_s2 <= pin_s1;
   end
   wire btn_raw   = pin_s2[4];
   wire supply_s  = pin_s2[3];
   wire fault_s   = pin_s2[2];
   wire ant_sh_s  = pin_s2[1];
   wire ant_op_s  = pin_s2[0];

   // Software-visible state
   logic [`SSL_CTRL_W-1:0]  ctrl;
   ssl_src_t                src;
   logic [`SSL_IRQ_W-1:0]   irq_stat;
   logic [`SSL_IRQ_W-1:0]   irq_mask;
   logic [`SSL_FW_W-1:0]    fwset;
   ssl_act_t                last_act;

   // One-second tick
   logic [SW-1:0] sec_cnt;
   wire           sec_tick = (sec_cnt == SW'(SEC_CYC - 1));
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         sec_cnt <= '0;
      else
         sec_cnt <= sec_tick ? '0 : sec_cnt + SW'(1);
   end

   // Flash sources
   logic slow_wave;
   logic fast_wave;
   ssl_flash #(.HALF_CYC(SEC_CYC / (2 * `SSL_SLOW_HZ))) u_slow
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .wave    (slow_wave)
   );
   ssl_flash #(.HALF_CYC(SEC_CYC / (2 * `SSL_FAST_HZ))) u_fast
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .wave    (fast_wave)
   );

   // Button debounce
   logic [DW-1:0] db_cnt;
   logic          btn_db;
   wire           db_diff = (btn_raw != btn_db);
   wire           db_done = (db_cnt == DW'(DEBOUNCE_CYC - 1));
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         db_cnt <= '0;
         btn_db <= 1'b0;
      end
      else
      begin
         db_cnt <= (db_diff && !db_done) ? db_cnt + DW'(1) : '0;
         btn_db <= (db_diff && db_done) ? btn_raw : btn_db;
      end
   end
   wire btn_press   = db_diff && db_done && btn_raw;
   wire btn_release = db_diff && db_done && !btn_raw;

   // Hold timing and release action
   ssl_btn_st_t   btn_st;
   ssl_btn_st_t   next_btn_st;
   logic [SW-1:0] hold_cyc;
   logic [4:0]    hold_s;
   logic [LW-1:0] rb_s;
   wire           hold_wrap = (hold_cyc == SW'(SEC_CYC - 1));
   wire           hold_sat  = (hold_s == 5'(`SSL_BAND_SHIP_S));
   wire           rb_done   = (rb_s == LW'(REBOOT_S - 1)) && sec_tick;

   wire band_rst  = (hold_s >= 5'(`SSL_PRESS_MIN_S)) && (hold_s < 5'(`SSL_BAND_USER_S));
   wire band_user = (hold_s >= 5'(`SSL_BAND_USER_S)) && (hold_s < 5'(`SSL_BAND_SHIP_S));
   wire band_ship = (hold_s >= 5'(`SSL_BAND_SHIP_S));
   wire user_ok   = ctrl[`SSL_CTRL_USER_SAVED];
   wire do_rst    = (btn_st == BTN_HELD) && btn_release && band_rst;
   wire do_user   = (btn_st == BTN_HELD) && btn_release && band_user && user_ok;
   wire do_ship   = (btn_st == BTN_HELD) && btn_release &&
                    (band_ship || (band_user && !user_ok));

   always_comb
   begin
      next_btn_st = btn_st;
      case (btn_st)
         BTN_IDLE:
            if (btn_press)
               next_btn_st = BTN_HELD;
         BTN_HELD:
            if (btn_release)
               next_btn_st = (do_user || do_ship) ? BTN_REBOOT : BTN_IDLE;
         BTN_REBOOT:
            if (rb_done)
               next_btn_st = BTN_IDLE;
         default:
            next_btn_st = BTN_IDLE;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         btn_st                  <= BTN_IDLE;
         hold_cyc                <= '0;
         hold_s                  <= '0;
         rb_s                    <= '0;
         last_act                <= ACT_NONE;
         hw_reset_req            <= 1'b0;
         user_preset_restore     <= 1'b0;
         shipping_preset_restore <= 1'b0;
         reboot_req              <= 1'b0;
      end
      else
      begin
         btn_st <= next_btn_st;
         if (btn_press && btn_st == BTN_IDLE)
         begin
            hold_cyc <= '0;
            hold_s   <= '0;
         end
         else if (btn_st == BTN_HELD && !hold_sat)
         begin
            hold_cyc <= hold_wrap ? '0 : hold_cyc + SW'(1);
            hold_s   <= hold_wrap ? hold_s + 5'd1 : hold_s;
         end
         if (btn_st != BTN_REBOOT)
            rb_s <= '0;
         else if (sec_tick)
            rb_s <= rb_s + LW'(1);
         hw_reset_req            <= do_rst;
         user_preset_restore     <= do_user;
         shipping_preset_restore <= do_ship;
         reboot_req              <= (btn_st == BTN_REBOOT) && rb_done;
         if (do_rst)
            last_act <= ACT_HW_RST;
         else if (do_user)
            last_act <= ACT_USER;
         else if (do_ship)
            last_act <= ACT_SHIP;
      end
   end

   // Boot supervision, restarted by any reset or reboot
   logic [LW-1:0] boot_s;
   logic [LW-1:0] settle_s;
   wire           restart    = hw_reset_req || reboot_req;
   wire           boot_end   = !net_ready && sec_tick && (boot_s == LW'(BOOT_S - 1));
   wire           locked_ok  = (src == SRC_LOCKED_REGULATED) && !fault_s;
   wire           settle_end = !stratum_top && net_ready && locked_ok && sec_tick &&
                               (settle_s == LW'(SETTLE_S - 1));
   always_ff @(posedge aclk)
   begin
      if (!aresetn || restart)
      begin
         boot_s    <= '0;
         net_ready <= 1'b0;
      end
      else
      begin
         boot_s    <= (!net_ready && sec_tick) ? boot_s + LW'(1) : boot_s;
         net_ready <= net_ready || boot_end;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn || restart || !net_ready || !locked_ok)
      begin
         settle_s    <= '0;
         stratum_top <= 1'b0;
      end
      else
      begin
         settle_s    <= (!stratum_top && sec_tick) ? settle_s + LW'(1) : settle_s;
         stratum_top <= stratum_top || settle_end;
      end
   end

   // LED table
   ssl_led_t red_mode;
   ssl_led_t grn_mode;
   logic     inv_grn;
   logic     not_valid;
   wire      set_miss = ctrl[`SSL_CTRL_SET_MISS];
   always_comb
   begin
      red_mode  = LED_OFF;
      grn_mode  = LED_OFF;
      inv_grn   = 1'b0;
      not_valid = 1'b0;
      if (!supply_s)
         not_valid = 1'b1;
      else if (fault_s)
      begin
         red_mode  = LED_FAST;
         not_valid = 1'b1;
      end
      else if (set_miss)
      begin
         red_mode  = LED_FAST;
         grn_mode  = LED_FAST;
         inv_grn   = 1'b1;
         not_valid = 1'b1;
      end
      else
      begin
         case (src)
            SRC_LOCKED_REGULATED:
               grn_mode = LED_ON;
            SRC_LOCKED_HOLDOFF:
               grn_mode = LED_SLOW;
            SRC_LOCKED_SIMULATED:
            begin
               red_mode = LED_SLOW;
               grn_mode = LED_ON;
            end
            SRC_QUARTZ_ACQUIRE:
            begin
               red_mode = LED_SLOW;
               grn_mode = LED_SLOW;
            end
            SRC_QUARTZ_EXT_SET:
            begin
               red_mode = LED_ON;
               grn_mode = LED_ON;
            end
            SRC_QUARTZ_MANUAL_SET:
            begin
               red_mode = LED_ON;
               grn_mode = LED_SLOW;
            end
            default:
            begin
               red_mode  = LED_ON;
               not_valid = 1'b1;
            end
         endcase
      end
   end

   wire red_lvl = (red_mode == LED_ON) || (red_mode == LED_SLOW && slow_wave) ||
                  (red_mode == LED_FAST && fast_wave);
   wire grn_lvl = (grn_mode == LED_ON) || (grn_mode == LED_SLOW && slow_wave) ||
                  (grn_mode == LED_FAST && (fast_wave ^ inv_grn));

   wire ant_now = ant_sh_s || ant_op_s;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         red_indicator     <= 1'b0;
         green_indicator   <= 1'b0;
         service_indicator <= 1'b0;
         time_not_valid    <= 1'b1;
         antenna_fault     <= 1'b0;
      end
      else
      begin
         red_indicator     <= red_lvl;
         green_indicator   <= grn_lvl;
         service_indicator <= net_ready && supply_s;
         time_not_valid    <= not_valid;
         antenna_fault     <= ant_now;
      end
   end

   // AXI4-Lite slave
   logic                   aw_full;
   logic                   w_full;
   logic [`SSL_ADDR_W-1:0] aw_addr;
   logic [31:0]            w_data;
   logic [3:0]             w_strb;
   assign s_axi_awready = !aw_full && !s_axi_bvalid;
   assign s_axi_wready  = !w_full && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   wire          do_wr    = aw_full && w_full && !s_axi_bvalid;
   wire [31:0]   wmask    = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
   wire [31:0]   wval     = w_data & wmask;
   wire          wr_ctrl  = do_wr && (aw_addr == `SSL_OFS_CTRL);
   wire          wr_src   = do_wr && (aw_addr == `SSL_OFS_SRC);
   wire          wr_istat = do_wr && (aw_addr == `SSL_OFS_IRQ_STAT);
   wire          wr_imask = do_wr && (aw_addr == `SSL_OFS_IRQ_MASK);
   wire          wr_fw    = do_wr && (aw_addr == `SSL_OFS_FWSET);
   wire          wr_hit   = wr_ctrl || wr_src || wr_istat || wr_imask ||
                            (aw_addr == `SSL_OFS_STATUS) || wr_fw;
   // Set complete when all required programs loaded
   wire          fw_done  = fwset[0] && fwset[2] && (fwset[1] || !fwset[`SSL_FW_OPT]);
   wire [`SSL_IRQ_W-1:0] ev = {btn_release && btn_st == BTN_HELD,
                               ant_now && !antenna_fault, settle_end, boot_end};

   wire [31:0] status_word = {22'h0, btn_st == BTN_REBOOT, fw_done, last_act, btn_db,
                              ant_op_s, ant_sh_s, time_not_valid, stratum_top, net_ready};
   wire        rd_ctrl  = (s_axi_araddr == `SSL_OFS_CTRL);
   wire        rd_src   = (s_axi_araddr == `SSL_OFS_SRC);
   wire        rd_stat  = (s_axi_araddr == `SSL_OFS_STATUS);
   wire        rd_istat = (s_axi_araddr == `SSL_OFS_IRQ_STAT);
   wire        rd_imask = (s_axi_araddr == `SSL_OFS_IRQ_MASK);
   wire        rd_fw    = (s_axi_araddr == `SSL_OFS_FWSET);
   wire        rd_hit   = rd_ctrl || rd_src || rd_stat || rd_istat || rd_imask || rd_fw;
   wire [31:0] rd_word  = rd_ctrl  ? {30'h0, ctrl} :
                          rd_src   ? {29'h0, src} :
                          rd_stat  ? status_word :
                          rd_istat ? {28'h0, irq_stat} :
                          rd_imask ? {28'h0, irq_mask} :
                          rd_fw    ? {28'h0, fwset} : 32'h0;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_full      <= 1'b0;
         w_full       <= 1'b0;
         aw_addr      <= '0;
         w_data       <= 32'h0;
         w_strb       <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'h0;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp  <= 2'h0;
         s_axi_rdata  <= 32'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_full <= 1'b1;
            aw_addr <= {s_axi_awaddr[`SSL_ADDR_W-1:2], 2'h0};
         end
         else if (do_wr)
            aw_full <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_full <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         else if (do_wr)
            w_full <= 1'b0;
         if (do_wr)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? 2'h0 : 2'h2;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_hit ? 2'h0 : 2'h2;
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // Registers; hardware set wins over write-one clear
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl     <= `SSL_CTRL_RST;
         src      <= ssl_src_t'(`SSL_SRC_RST);
         irq_stat <= `SSL_IRQ_RST;
         irq_mask <= `SSL_IRQ_RST;
         fwset    <= `SSL_FW_RST;
      end
      else
      begin
         if (wr_ctrl)
            ctrl <= (ctrl & ~wmask[`SSL_CTRL_W-1:0]) | wval[`SSL_CTRL_W-1:0];
         if (wr_src && w_strb[0])
            src <= ssl_src_t'(w_data[`SSL_SRC_W-1:0]);
         if (wr_imask)
            irq_mask <= (irq_mask & ~wmask[`SSL_IRQ_W-1:0]) | wval[`SSL_IRQ_W-1:0];
         if (wr_fw)
            fwset <= (fwset & ~wmask[`SSL_FW_W-1:0]) | wval[`SSL_FW_W-1:0];
         irq_stat <= (irq_stat & ~(wr_istat ? wval[`SSL_IRQ_W-1:0] : `SSL_IRQ_RST)) | ev;
      end
   end

   assign irq = |(irq_stat & irq_mask);

endmodule
`default_nettype wire

// File: src/ssl_regs.svh
// Offsets, field positions, reset values and timing figures of the status/button block
`ifndef SSL_REGS_SVH
`define SSL_REGS_SVH

`define SSL_ADDR_W          6
`define SSL_OFS_CTRL        6'h00
`define SSL_OFS_SRC         6'h04
`define SSL_OFS_STATUS      6'h08
`define SSL_OFS_IRQ_STAT    6'h0c
`define SSL_OFS_IRQ_MASK    6'h10
`define SSL_OFS_FWSET       6'h14

`define SSL_CTRL_USER_SAVED 0
`define SSL_CTRL_SET_MISS   1
`define SSL_CTRL_W          2
`define SSL_CTRL_RST        2'h0

`define SSL_SRC_W           3
`define SSL_SRC_RST         3'h6

`define SSL_ST_NET_READY    0
`define SSL_ST_STRATUM_TOP  1
`define SSL_ST_NOT_VALID    2
`define SSL_ST_ANT_SHORT    3
`define SSL_ST_ANT_OPEN     4
`define SSL_ST_BTN_DOWN     5
`define SSL_ST_LAST_ACT     6
`define SSL_ST_FW_DONE      8
`define SSL_ST_RB_PEND      9

`define SSL_IRQ_BOOT        0
`define SSL_IRQ_SETTLED     1
`define SSL_IRQ_ANT         2
`define SSL_IRQ_BTN         3
`define SSL_IRQ_W           4
`define SSL_IRQ_RST         4'h0

`define SSL_FW_W            4
`define SSL_FW_OPT          3
`define SSL_FW_RST          4'h0

`define SSL_CLK_NS          25
`define SSL_SEC_NS          1000000000
`define SSL_SEC_CYC         (`SSL_SEC_NS / `SSL_CLK_NS)
`define SSL_DEBOUNCE_MS     20
`define SSL_DEBOUNCE_CYC    ((`SSL_DEBOUNCE_MS * 1000000) / `SSL_CLK_NS)
`define SSL_FAST_HZ         3
`define SSL_SLOW_HZ         1
`define SSL_PRESS_MIN_S     1
`define SSL_BAND_USER_S     10
`define SSL_BAND_SHIP_S     20
`define SSL_REBOOT_S        10
`define SSL_BOOT_S          60
`define SSL_SETTLE_S        300

`endif

// File: src/ssl_pkg.sv
// Types of the status/button block
package ssl_pkg;

   // Time-source state as forwarded by software
   typedef enum logic [2:0]
   {
      SRC_LOCKED_REGULATED   = 3'b000,
      SRC_LOCKED_HOLDOFF     = 3'b001,
      SRC_LOCKED_SIMULATED   = 3'b010,
      SRC_QUARTZ_ACQUIRE     = 3'b011,
      SRC_QUARTZ_EXT_SET     = 3'b100,
      SRC_QUARTZ_MANUAL_SET  = 3'b101,
      SRC_TIME_NOT_VALID     = 3'b110
   } ssl_src_t;

   typedef enum logic [1:0]
   {
      BTN_IDLE   = 2'b00,
      BTN_HELD   = 2'b01,
      BTN_REBOOT = 2'b10
   } ssl_btn_st_t;

   typedef enum logic [1:0]
   {
      ACT_NONE    = 2'b00,
      ACT_HW_RST  = 2'b01,
      ACT_USER    = 2'b10,
      ACT_SHIP    = 2'b11
   } ssl_act_t;

   typedef enum logic [1:0]
   {
      LED_OFF   = 2'b00,
      LED_ON    = 2'b01,
      LED_SLOW  = 2'b10,
      LED_FAST  = 2'b11
   } ssl_led_t;

endpackage

// File: src/ssl_flash.sv
// Free-running square wave with a fixed half period
`timescale 1ns/1ps
`default_nettype none

module ssl_flash
#(
   parameter int unsigned HALF_CYC = 1000
)
(
   input  wire logic aclk,
   input  wire logic aresetn,
   output var  logic wave
);
   localparam int unsigned CW = (HALF_CYC > 1) ? $clog2(HALF_CYC) : 1;

   logic [CW-1:0] cnt;
   wire           wrap = (cnt == CW'(HALF_CYC - 1));

   if (HALF_CYC < 1)
   begin : g_bad
      $error("ssl_flash: half period must be at least one cycle");
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cnt  <= '0;
         wave <= 1'b0;
      end
      else
      begin
         cnt  <= wrap ? '0 : cnt + CW'(1);
         wave <= wrap ? ~wave : wave;
      end
   end

endmodule
`default_nettype wire

// File: tb/ssl_properties.sv
// Port assertions of the status/button block
`timescale 1ns/1ps
`default_nettype none

module ssl_properties
(
   input wire logic       aclk,
   input wire logic       aresetn,
   input wire logic       s_axi_bvalid,
   input wire logic       s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic       supply_ok,
   input wire logic       general_module_fault,
   input wire logic       antenna_short,
   input wire logic       red_indicator,
   input wire logic       green_indicator,
   input wire logic       time_not_valid,
   input wire logic       antenna_fault,
   input wire logic       hw_reset_req,
   input wire logic       user_preset_restore,
   input wire logic       shipping_preset_restore,
   input wire logic       net_ready
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   dark_no_supply_a: assert property (
      !supply_ok [*4] |-> !red_indicator && !green_indicator)
      else $error("indicator lit without supply");
   fault_red_only_a: assert property (
      (supply_ok && general_module_fault) [*4] |-> !green_indicator && time_not_valid)
      else $error("fault display wrong");
   antenna_error_a: assert property (
      antenna_short [*4] |-> antenna_fault)
      else $error("antenna short not flagged");
   reset_pulse_a: assert property (
      hw_reset_req |=> !hw_reset_req)
      else $error("hardware reset pulse too long");
   restore_single_a: assert property (
      user_preset_restore |-> !shipping_preset_restore && !hw_reset_req)
      else $error("two actions at once");
   ship_pulse_a: assert property (
      shipping_preset_restore |=> $fell(shipping_preset_restore))
      else $error("shipping restore pulse too long");
   boot_restart_a: assert property (
      hw_reset_req |-> ##[1:2] !net_ready)
      else $error("boot not restarted");
   bresp_hold_a: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
endmodule

bind ssl_top ssl_properties props (.*);

`default_nettype wire

// File: tb/ssl_button_model.sv
// Operator push-button with pull-up, held low for a set time
`timescale 1ns/1ps
`default_nettype none

module ssl_button_model
(
   input  wire logic        aclk,
   input  wire logic        go,
   input  wire logic [31:0] hold_cyc,
   output var  logic        button_n
);
   int n = 0;

   initial button_n = 1'b1;

   // Pull-up restores the high level on release
   always @(posedge aclk)
   begin
      if (go)
         n <= hold_cyc;
      else if (n > 0)
         n <= n - 1;
      button_n <= !(go || n > 1);
   end
endmodule

`default_nettype wire

// File: tb/sync_status_led_reset_button_tb.sv
// Random and corner-case bench of the status/button block
`timescale 1ns/1ps
`default_nettype none

module sync_status_led_reset_button_tb;
   localparam int S = 60;
   logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, supply_ok = 1, general_module_fault = 0;
   logic antenna_short = 0, antenna_open = 0, go = 0, button_n;
   logic [5:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, q, rnd = 32'h00013b6a;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   logic red_indicator, green_indicator, service_indicator, time_not_valid, antenna_fault;
   logic net_ready, stratum_top, hw_reset_req, user_preset_restore, shipping_preset_restore;
   logic reboot_req;
   logic [3:0] led_exp [11] = '{4'h1, 4'h2, 4'h9, 4'ha, 4'h5, 4'h6, 4'h4, 4'h4, 4'hc, 4'hf, 4'h0};
   int errors = 0, comparisons = 0, hold_cyc = 0, i, k;
   int base [5] = '{0, 1, 10, 10, 20};
   int span [5] = '{1, 9, 10, 10, 5};

   always #12.5 aclk = !aclk;

   ssl_top #(.SEC_CYC(S), .DEBOUNCE_CYC(2), .BOOT_S(2), .SETTLE_S(2), .REBOOT_S(2)) dut (.*);
   ssl_button_model panel (.aclk(aclk), .go(go), .hold_cyc(hold_cyc), .button_n(button_n));

   function logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction

   // Kinds per lamp: 0 off, 1 steady, 2 slow, 3 fast
   function logic [1:0] kind(input int t, input logic v);
      return t == 0 ? {1'b0, v} : (t < 8 ? 2'd2 : 2'd3);
   endfunction

   function logic [1:0] exp_act(input int s, input logic saved);
      if (s < 1)
         return 2'd0;
      if (s < 10)
         return 2'd1;
      return (s < 20 && saved) ? 2'd2 : 2'd3;
   endfunction

   task print_verdict;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e)
      begin
         errors++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task expire(input int n);
      if (k >= n)
      begin
         errors++;
         print_verdict;
      end
   endtask
   task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      logic pa, pw, tk, tw, tr;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= w;
      s_axi_wvalid <= w;
      s_axi_arvalid <= !w;
      s_axi_rready <= !w;
      pa = 1'b1;
      pw = w;
      tr = 1'b0;
      for (k = 0; k < 40 && !tr; k++)
      begin
         @(negedge aclk);
         tk = pa && (w ? s_axi_awready : s_axi_arready);
         tw = pw && s_axi_wready;
         tr = w ? s_axi_bvalid && s_axi_bready : s_axi_rvalid;
         q = w ? 32'(s_axi_bresp) : s_axi_rdata;
         @(posedge aclk);
         pa = pa && !tk;
         pw = pw && !tw;
         s_axi_awvalid <= w && pa;
         s_axi_wvalid <= pw;
         s_axi_arvalid <= !w && pa;
         s_axi_bready <= w && !tr && k > 1;
         s_axi_rready <= !w && !tr;
      end
      expire(40);
   endtask

   task led(input int c);
      int tr, tg, eq;
      logic pr, pg;
      tr = 0;
      tg = 0;
      eq = 0;
      repeat (8) @(posedge aclk);
      @(negedge aclk);
      pr = red_indicator;
      pg = green_indicator;
      repeat (2 * S)
      begin
         @(negedge aclk);
         tr += (red_indicator !== pr);
         tg += (green_indicator !== pg);
         eq += (red_indicator === green_indicator);
         pr = red_indicator;
         pg = green_indicator;
      end
      chk("leds", led_exp[c], {kind(tr, pr), kind(tg, pg)});
      if (c == 9)
         chk("phase", 0, eq);
   endtask

   task press(input int s, input logic saved);
      logic [1:0] a;
      bus(1, 6'h00, {31'h0, saved});
      hold_cyc <= s * S + S / 2;
      go <= 1'b1;
      @(posedge aclk);
      go <= 1'b0;
      a = 2'd0;
      for (k = 0; k < s * S + 2 * S && a == 2'd0; k++)
      begin
         @(negedge aclk);
         a = shipping_preset_restore ? 2'd3 : user_preset_restore ? 2'd2 : {1'b0, hw_reset_req};
      end
      chk("action", exp_act(s, saved), a);
      if (a[1])
      begin
         for (k = 0; k < 5 * S && reboot_req !== 1'b1; k++)
            @(negedge aclk);
         expire(5 * S);
         chk("reboot delay", 1, k > S / 2);
      end
      chk("irq", 1, irq);
      bus(1, 6'h0c, 32'h8);
      chk("irq clear", 0, irq);
   endtask

   initial
   begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      bus(0, 6'h04, 0);
      chk("source reset", 6, q);
      bus(1, 6'h18, 0);
      chk("unmapped", 2, q);
      for (k = 0; k < 4 * S && net_ready !== 1'b1; k++)
         @(negedge aclk);
      expire(4 * S);
      @(negedge aclk);
      chk("service", 1, service_indicator);
      bus(1, 6'h04, 0);
      for (k = 0; k < 5 * S && stratum_top !== 1'b1; k++)
         @(negedge aclk);
      expire(5 * S);
      chk("settle", 1, k > S);
      @(posedge aclk);
      antenna_open <= 1'b1;
      repeat (8) @(negedge aclk);
      chk("open input", 1, antenna_fault);
      @(posedge aclk);
      antenna_open <= 1'b0;
      antenna_short <= 1'b1;
      bus(1, 6'h0c, 32'hf);
      antenna_short <= 1'b0;
      bus(1, 6'h10, 32'h8);
      for (i = 0; i < 8; i++)
      begin
         rnd = lfsr(rnd);
         bus(1, 6'h14, rnd);
         bus(0, 6'h08, 0);
         chk("fw set", rnd[0] & rnd[2] & (rnd[1] | ~rnd[3]), q[8]);
         bus(1, 6'h04, {rnd[31:3], i[2:0]});
         led(i);
      end
      @(posedge aclk);
      general_module_fault <= 1'b1;
      led(8);
      bus(1, 6'h00, 32'h2);
      general_module_fault <= 1'b0;
      led(9);
      chk("invalid", 1, time_not_valid);
      for (i = 0; i < 5; i++)
      begin
         rnd = lfsr(rnd);
         press(base[i] + rnd[7:0] % span[i], i > 2);
      end
      supply_ok <= 1'b0;
      led(10);
      print_verdict;
   end
endmodule

`default_nettype wire
